// ### common/asop_pkg.sv
// constants for the converter serial result port
package asop_pkg;
   // ------------------------------------------------------------------
   // register map (byte offsets)
   // ------------------------------------------------------------------
   localparam logic [3:0] OFS_STATUS = 4'h0;
   localparam logic [3:0] OFS_MASK = 4'h4;
   localparam logic [3:0] OFS_STATE = 4'h8;
   localparam logic [3:0] OFS_RESULT = 4'hc;
   // status / mask bit positions
   localparam int BIT_READ_DONE = 0;
   localparam int BIT_INCOMPLETE = 1;
   localparam int EVENT_COUNT = 2;
   // reset values
   localparam logic [1:0] STATUS_RESET = 2'h0;
   localparam logic [1:0] MASK_RESET = 2'h0;
   localparam logic [15:0] RESULT_RESET = 16'h0000;
   // ------------------------------------------------------------------
   // shift timing
   // ------------------------------------------------------------------
   localparam int WORD_BITS = 16;
   localparam logic [4:0] WORD_BITS_COUNT = 5'h10;
   // core clocks per half period of the undivided internal shift clock
   localparam logic [7:0] HALF_BASE_CYCLES = 8'h02;
   // shared configuration pin positions (pins d2..d7)
   localparam int PIN_DIV0 = 0;
   localparam int PIN_DIV1 = 1;
   localparam int PIN_CLK_SRC = 2;
   localparam int PIN_SYNC_POL = 3;
   localparam int PIN_CLK_INV = 4;
   localparam int PIN_READ_MODE_OR_CHAIN_INPUT = 5;
   localparam int PIN_COUNT = 6;
   // port states
   typedef enum logic [2:0]
   {
      ST_IDLE = 3'b001,
      ST_MASTER = 3'b010,
      ST_SLAVE = 3'b100
   } asop_state_type;
endpackage : asop_pkg

// ### common/asop_shift_if.sv
// link between the port controller and the result shift register
`timescale 1ns/1ps
`default_nettype none
interface asop_shift_if;
   logic load;
   logic [15:0] load_word;
   logic shift;
   logic chain_bit;
   logic msb;
   logic [4:0] bits_left;
   modport ctrl (output load, output load_word, output shift,
      output chain_bit, input msb, input bits_left);
   modport engine (input load, input load_word, input shift,
      input chain_bit, output msb, output bits_left);
endinterface : asop_shift_if
`default_nettype wire

// ### core/asop_shift_engine.sv
// sixteen-bit result shift register with chain input
`timescale 1ns/1ps
`default_nettype none
module asop_shift_engine
(
   input wire logic i_clk,
   input wire logic i_rst_n,
   asop_shift_if.engine sh
);
   logic [15:0] sr;
   logic [4:0] left;

   // ------------------------------------------------------------------
   // shift register, msb leaves first, chain bit enters at the bottom
   // ------------------------------------------------------------------
   always_ff @(posedge i_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         sr <= asop_pkg::RESULT_RESET;
         left <= 5'h00;
      end
      else if (sh.load)
      begin
         sr <= sh.load_word;
         left <= asop_pkg::WORD_BITS_COUNT;
      end
      else if (sh.shift)
      begin
         sr <= {sr[14:0], sh.chain_bit};
         left <= (left == 5'h00) ? 5'h00 : left - 5'h01;
      end
   end

   assign sh.msb = sr[15];
   assign sh.bits_left = left;

   // ------------------------------------------------------------------
   // checks
   // ------------------------------------------------------------------
   property p_msb_first;
      @(posedge i_clk) disable iff (!i_rst_n)
      sh.load |=> sh.msb == $past(sh.load_word[15]);
   endproperty
   a_msb_first: assert property (p_msb_first)
      else $error("msb not presented first after load");

   property p_chain_enters;
      @(posedge i_clk) disable iff (!i_rst_n)
      (sh.shift && !sh.load) |=> sr[0] == $past(sh.chain_bit);
   endproperty
   a_chain_enters: assert property (p_chain_enters)
      else $error("chain bit not taken into the shift register");
endmodule : asop_shift_engine
`default_nettype wire

// ### core/asop_serial_port.sv
// serial result port of the sampling converter
//
// Our own choices: the placing of the registers and the Avalon-MM interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module asop_serial_port
(
   input wire logic i_core_clk,
   input wire logic i_rst_n,
   // avalon-mm slave
   input wire logic [3:0] i_avs_address,
   input wire logic i_avs_read,
   input wire logic i_avs_write,
   input wire logic [31:0] i_avs_writedata,
   output logic [31:0] o_avs_readdata,
   output logic o_avs_waitrequest,
   output logic o_irq,
   // converter core, same clock
   input wire logic i_conv_busy,
   input wire logic i_conv_done,
   input wire logic [15:0] i_conv_result,
   // pins
   input wire logic i_serial_parallel_select,
   input wire logic [5:0] i_cfg_pin,
   output logic [5:0] o_cfg_pin,
   output logic [5:0] o_cfg_pin_oe,
   input wire logic i_shift_clock,
   output logic o_shift_clock,
   output logic o_shift_clock_oe,
   input wire logic i_chip_select_n,
   output logic o_serial_data_out,
   output logic o_frame_sync,
   output logic o_incomplete_read_flag
);
   // ------------------------------------------------------------------
   // reset release and pin synchronisers
   // ------------------------------------------------------------------
   logic [1:0] rst_pipe;
   logic rst_n;
   logic [8:0] pin_meta;
   logic [8:0] pin_sync;

   always_ff @(posedge i_core_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
         rst_pipe <= 2'h0;
      else
         rst_pipe <= {rst_pipe[0], 1'b1};
   end
   assign rst_n = rst_pipe[1];

   always_ff @(posedge i_core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         pin_meta <= 9'h100;
         pin_sync <= 9'h100;
      end
      else
      begin
         pin_meta <= {i_chip_select_n, i_shift_clock,
            i_serial_parallel_select, i_cfg_pin};
         pin_sync <= pin_meta;
      end
   end

   // ------------------------------------------------------------------
   // mode decode
   // ------------------------------------------------------------------
   wire serial_sel = pin_sync[6];
   wire sclk_in = pin_sync[7];
   wire cs_n = pin_sync[8];
   wire slave_cfg = pin_sync[asop_pkg::PIN_CLK_SRC];
   wire sync_pol = pin_sync[asop_pkg::PIN_SYNC_POL];
   wire clk_inv = pin_sync[asop_pkg::PIN_CLK_INV];
   wire rdc_chain = pin_sync[asop_pkg::PIN_READ_MODE_OR_CHAIN_INPUT];
   wire master_mode = serial_sel && !slave_cfg;
   wire slave_mode = serial_sel && slave_cfg;
   wire divided = master_mode && !rdc_chain;
   wire [1:0] div_eff = divided ?
      pin_sync[asop_pkg::PIN_DIV1:asop_pkg::PIN_DIV0] : 2'h0;
   wire [7:0] half_cycles = asop_pkg::HALF_BASE_CYCLES << div_eff;

   // ------------------------------------------------------------------
   // state
   // ------------------------------------------------------------------
   asop_pkg::asop_state_type state;
   asop_pkg::asop_state_type next_state;
   asop_shift_if sh ();
   logic [15:0] result;
   logic busy_prev;
   logic mclk;
   logic [7:0] half_cnt;
   logic sclk_prev;
   logic flag_pulse;
   logic cs_prev;

   wire busy_rise = i_conv_busy && !busy_prev;
   wire master_start = master_mode && ((rdc_chain && busy_rise) ||
      (!rdc_chain && i_conv_done));
   // a start during a running frame is refused
   wire m_load = master_start && (state == asop_pkg::ST_IDLE);
   wire half_end = (half_cnt == half_cycles - 8'h01);
   wire m_fall = (state == asop_pkg::ST_MASTER) && half_end && mclk;
   wire m_last = m_fall && (sh.bits_left == 5'h01);
   wire sclk_eff = sclk_in ^ clk_inv;
   wire upd_edge = sclk_eff && !sclk_prev;
   // a new read needs chip select to rise and fall again, also after a drop
   wire cs_fall = !cs_n && cs_prev;
   wire slave_start = slave_mode && cs_fall &&
      (state == asop_pkg::ST_IDLE) && !flag_pulse;
   wire s_active = (state == asop_pkg::ST_SLAVE) && !cs_n;
   wire s_shift = s_active && upd_edge;
   wire s_last = s_shift && (sh.bits_left == 5'h01);
   wire s_abort = (state == asop_pkg::ST_SLAVE) && i_conv_done &&
      (sh.bits_left != 5'h00);

   always_comb
   begin
      next_state = state;
      unique case (state)
         asop_pkg::ST_IDLE:
            if (master_start)
               next_state = asop_pkg::ST_MASTER;
            else if (slave_start)
               next_state = asop_pkg::ST_SLAVE;
         asop_pkg::ST_MASTER:
            if (m_last || !master_mode)
               next_state = asop_pkg::ST_IDLE;
         asop_pkg::ST_SLAVE:
            if (cs_n || s_abort || !slave_mode)
               next_state = asop_pkg::ST_IDLE;
         default:
            next_state = asop_pkg::ST_IDLE;
      endcase
   end

   always_ff @(posedge i_core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         state <= asop_pkg::ST_IDLE;
         result <= asop_pkg::RESULT_RESET;
         busy_prev <= 1'b0;
         sclk_prev <= 1'b0;
         cs_prev <= 1'b1;
         flag_pulse <= 1'b0;
      end
      else
      begin
         state <= next_state;
         if (i_conv_done)
            result <= i_conv_result;
         busy_prev <= i_conv_busy;
         sclk_prev <= sclk_eff;
         cs_prev <= cs_n;
         flag_pulse <= s_abort;
      end
   end

   // ------------------------------------------------------------------
   // internal shift clock generator
   // ------------------------------------------------------------------
   always_ff @(posedge i_core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         mclk <= 1'b0;
         half_cnt <= 8'h00;
      end
      else if (state != asop_pkg::ST_MASTER)
      begin
         mclk <= 1'b0;
         half_cnt <= 8'h00;
      end
      else
      begin
         half_cnt <= half_end ? 8'h00 : half_cnt + 8'h01;
         mclk <= half_end ? !mclk : mclk;
      end
   end

   // ------------------------------------------------------------------
   // shift engine
   // ------------------------------------------------------------------
   // master with read mode high sends the stored previous result
   assign sh.load = m_load || slave_start;
   assign sh.load_word = (master_start && !rdc_chain) ? i_conv_result :
      result;
   assign sh.shift = m_fall || s_shift;
   assign sh.chain_bit = slave_mode ? rdc_chain : 1'b0;

   asop_shift_engine u_engine
   (
      .i_clk(i_core_clk),
      .i_rst_n(rst_n),
      .sh(sh)
   );

   // ------------------------------------------------------------------
   // pin drivers
   // ------------------------------------------------------------------
   wire m_frame = (state == asop_pkg::ST_MASTER);
   assign o_serial_data_out = serial_sel && sh.msb;
   assign o_frame_sync = master_mode && (m_frame ^ sync_pol);
   assign o_shift_clock = mclk ^ clk_inv;
   assign o_shift_clock_oe = master_mode;
   assign o_incomplete_read_flag = flag_pulse;
   // parallel mode drives result bits 4..7 onto pins d4..d7
   assign o_cfg_pin = serial_sel ? 6'h00 : {result[7:4], 2'h0};
   assign o_cfg_pin_oe = serial_sel ? 6'h00 : 6'h3c;

   // ------------------------------------------------------------------
   // register bus and interrupts
   // ------------------------------------------------------------------
   logic ack;
   logic [1:0] status;
   logic [1:0] mask;
   wire req = i_avs_read || i_avs_write;
   wire wr_take = i_avs_write && ack;
   wire sel_status = (i_avs_address == asop_pkg::OFS_STATUS);
   wire sel_mask = (i_avs_address == asop_pkg::OFS_MASK);
   wire sel_state = (i_avs_address == asop_pkg::OFS_STATE);
   wire sel_result = (i_avs_address == asop_pkg::OFS_RESULT);
   wire [1:0] ev_set = {flag_pulse, m_last || s_last};
   wire [1:0] ev_clr = (wr_take && sel_status) ? i_avs_writedata[1:0] :
      2'h0;
   wire [31:0] rd_mux = sel_status ? {30'h0, status} :
      sel_mask ? {30'h0, mask} :
      sel_state ? {19'h0, sh.bits_left, rdc_chain, clk_inv, sync_pol,
         slave_cfg, serial_sel, state} :
      sel_result ? {16'h0, result} : 32'h0;

   assign o_avs_waitrequest = req && !ack;
   assign o_irq = |(status & mask);

   always_ff @(posedge i_core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         ack <= 1'b0;
         status <= asop_pkg::STATUS_RESET;
         mask <= asop_pkg::MASK_RESET;
         o_avs_readdata <= 32'h0;
      end
      else
      begin
         ack <= req && !ack;
         // a new event wins over a clear in the same cycle
         status <= (status & ~ev_clr) | ev_set;
         if (wr_take && sel_mask)
            mask <= i_avs_writedata[1:0];
         if (i_avs_read && !ack)
            o_avs_readdata <= rd_mux;
      end
   end

   // ------------------------------------------------------------------
   // checks
   // ------------------------------------------------------------------
   property p_div_used;
      @(posedge i_core_clk) disable iff (!rst_n)
      divided |-> half_cycles == (asop_pkg::HALF_BASE_CYCLES <<
         pin_sync[asop_pkg::PIN_DIV1:asop_pkg::PIN_DIV0]);
   endproperty
   a_div_used: assert property (p_div_used)
      else $error("divider pins not applied in master read-after mode");

   property p_div_ignored;
      @(posedge i_core_clk) disable iff (!rst_n)
      !divided |-> half_cycles == asop_pkg::HALF_BASE_CYCLES;
   endproperty
   a_div_ignored: assert property (p_div_ignored)
      else $error("divider pins used outside master read-after mode");

   property p_master_drives;
      @(posedge i_core_clk) disable iff (!rst_n)
      (m_frame && half_end && !mclk) |=> o_shift_clock == !clk_inv;
   endproperty
   a_master_drives: assert property (p_master_drives)
      else $error("internal shift clock did not rise");

   property p_cs_gate;
      @(posedge i_core_clk) disable iff (!rst_n)
      (slave_mode && cs_n) |-> !sh.shift;
   endproperty
   a_cs_gate: assert property (p_cs_gate)
      else $error("shift while chip select inactive");

   property p_sync_level;
      @(posedge i_core_clk) disable iff (!rst_n)
      (m_frame && master_mode) |-> o_frame_sync != sync_pol;
   endproperty
   a_sync_level: assert property (p_sync_level)
      else $error("frame sync not at its active level");

   property p_idle_clock;
      @(posedge i_core_clk) disable iff (!rst_n)
      (state == asop_pkg::ST_IDLE) |-> o_shift_clock == clk_inv;
   endproperty
   a_idle_clock: assert property (p_idle_clock)
      else $error("idle shift clock level ignores invert pin");

   property p_rdc_high;
      @(posedge i_core_clk) disable iff (!rst_n)
      (master_start && rdc_chain) |-> busy_rise;
   endproperty
   a_rdc_high: assert property (p_rdc_high)
      else $error("read-during start not at conversion start");

   property p_rdc_low;
      @(posedge i_core_clk) disable iff (!rst_n)
      (master_start && !rdc_chain) |-> i_conv_done;
   endproperty
   a_rdc_low: assert property (p_rdc_low)
      else $error("read-after start before conversion end");

   property p_parallel;
      @(posedge i_core_clk) disable iff (!rst_n)
      !serial_sel |-> o_cfg_pin_oe == 6'h3c && o_cfg_pin[5:2] == result[7:4];
   endproperty
   a_parallel: assert property (p_parallel)
      else $error("parallel bits 4-7 not driven");

   property p_slave_edge;
      @(posedge i_core_clk) disable iff (!rst_n)
      s_shift |-> !$past(sclk_eff) && sclk_eff;
   endproperty
   a_slave_edge: assert property (p_slave_edge)
      else $error("slave update on the wrong edge");

   property p_sync_hold;
      @(posedge i_core_clk) disable iff (!rst_n)
      (master_start && state == asop_pkg::ST_IDLE) |=>
         (o_frame_sync != sync_pol) [*2];
   endproperty
   a_sync_hold: assert property (p_sync_hold)
      else $error("frame sync dropped early in a frame");

   property p_flag_pulse;
      @(posedge i_core_clk) disable iff (!rst_n)
      s_abort |=> o_incomplete_read_flag ##1 !o_incomplete_read_flag;
   endproperty
   a_flag_pulse: assert property (p_flag_pulse)
      else $error("incomplete read flag not a one-cycle pulse");

   c_master_frame: cover property (@(posedge i_core_clk) disable iff (!rst_n)
      m_last);
   c_slave_frame: cover property (@(posedge i_core_clk) disable iff (!rst_n)
      s_last);
   c_abort: cover property (@(posedge i_core_clk) disable iff (!rst_n)
      s_abort);
   c_irq: cover property (@(posedge i_core_clk) disable iff (!rst_n)
      o_irq);
endmodule : asop_serial_port
`default_nettype wire

// ### tb/asop_host_model.sv
// host side model that reads results from the serial port
`timescale 1ns/1ps
`default_nettype none
module asop_host_model
(
   input wire logic i_sclk,
   input wire logic i_master,
   input wire logic i_sync,
   input wire logic i_serial_data_out,
   input wire logic i_inv,
   input wire logic i_pol,
   output logic o_sclk,
   output logic o_cs_n,
   output logic o_sdin
);
   logic [15:0] m_word;
   int m_bits;
   // ------------------------------------------------------------------
   // master: sample on each rising internal clock inside the frame
   // ------------------------------------------------------------------
   always @(posedge (i_sclk ^ i_inv))
   begin
      if (i_master && ((i_sync ^ i_pol) === 1'b1))
      begin
         m_word = {m_word[14:0], i_serial_data_out};
         m_bits++;
      end
   end
   initial
   begin
      o_sclk = 1'b0;
      o_cs_n = 1'b1;
      o_sdin = 1'b0;
      m_bits = 0;
      m_word = 16'h0000;
   end
   // ------------------------------------------------------------------
   // slave read: the clock runs only while the port is selected
   // ------------------------------------------------------------------
   task slave_read(input logic inv, input logic [15:0] chain,
      input int nbits, output logic [31:0] word);
      int i;
      begin
         o_sclk = inv;
         o_cs_n = 1'b0;
         word = 32'h0;
         #125;
         for (i = 0; i < nbits; i++)
         begin
            o_sdin = chain[15 - (i % 16)];
            #62.5;
            word = {word[30:0], i_serial_data_out};
            o_sclk = ~inv;
            #62.5;
            o_sclk = inv;
         end
         o_cs_n = 1'b1;
         // released line shows no stale level
         o_sdin = ~o_sdin;
      end
   endtask : slave_read
endmodule : asop_host_model
`default_nettype wire

// ### tb/tb_top.sv
// self-checking bench for the converter serial result port
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   logic clk;
   logic rst_n;
   logic [3:0] adr;
   logic rd;
   logic wr;
   logic [31:0] wdata;
   logic [31:0] rdata;
   logic [31:0] got;
   logic wait_req;
   logic irq;
   logic busy;
   logic done;
   logic [15:0] result;
   logic ser;
   logic [4:0] cfg;
   logic rdc;
   logic rdc_pin;
   logic [5:0] cfg_in;
   logic [5:0] cfg_out;
   logic [5:0] cfg_oe;
   logic sclk_dev;
   logic sclk_oe;
   logic sclk_host;
   logic sclk_pin;
   logic cs_n;
   logic serial_data_out;
   logic sync;
   logic flag;
   logic sdin;
   logic [15:0] last;
   logic [15:0] r;
   logic [15:0] chain;
   logic [31:0] word;
   int n_mismatch;
   int n_checks;
   int seed;
   int n_flag;
   int n_sync;
   int k;
   assign sclk_pin = sclk_oe ? sclk_dev : sclk_host;
   assign rdc_pin = cfg[2] ? sdin : rdc;
   assign cfg_in = (cfg_oe & cfg_out) | (~cfg_oe & {rdc_pin, cfg});
   asop_serial_port uut
   (
      .i_core_clk(clk), .i_rst_n(rst_n), .i_avs_address(adr),
      .i_avs_read(rd), .i_avs_write(wr), .i_avs_writedata(wdata),
      .o_avs_readdata(rdata), .o_avs_waitrequest(wait_req), .o_irq(irq),
      .i_conv_busy(busy), .i_conv_done(done), .i_conv_result(result),
      .i_serial_parallel_select(ser), .i_cfg_pin(cfg_in),
      .o_cfg_pin(cfg_out), .o_cfg_pin_oe(cfg_oe), .i_shift_clock(sclk_pin),
      .o_shift_clock(sclk_dev), .o_shift_clock_oe(sclk_oe),
      .i_chip_select_n(cs_n), .o_serial_data_out(serial_data_out),
      .o_frame_sync(sync), .o_incomplete_read_flag(flag)
   );
   asop_host_model host
   (
      .i_sclk(sclk_pin), .i_master(sclk_oe), .i_sync(sync),
      .i_serial_data_out(serial_data_out), .i_inv(cfg[4]), .i_pol(cfg[3]),
      .o_sclk(sclk_host), .o_cs_n(cs_n), .o_sdin(sdin)
   );
   always #5 clk = ~clk;
   // counted on the falling edge, where the outputs have settled
   always @(negedge clk)
   begin
      if (flag === 1'b1)
         n_flag++;
      if (sclk_oe === 1'b1 && (sync ^ cfg[3]) === 1'b1)
         n_sync++;
   end
   // ------------------------------------------------------------------
   // shared tasks
   // ------------------------------------------------------------------
   task chk(input string what, input logic [31:0] exp,
      input logic [31:0] seen);
      n_checks++;
      if (seen !== exp)
      begin
         n_mismatch++;
         $display("mismatch %s expected %h seen %h", what, exp, seen);
      end
   endtask : chk
   // divider pins apply only in master read-after-convert
   function automatic int exp_half(input logic [1:0] div, input logic mode);
      return mode ? 2 : (2 << div);
   endfunction : exp_half
   task bus(input logic w, input logic [3:0] a, input logic [31:0] d);
      int t;
      begin
         @(posedge clk);
         adr <= a;
         wr <= w;
         rd <= ~w;
         wdata <= d;
         t = 0;
         // waitrequest and read data are looked at where they have settled
         do
         begin
            @(negedge clk);
            t++;
         end
         while (wait_req !== 1'b0 && t < 40);
         got = rdata;
         @(posedge clk);
         if (t >= 40)
            n_mismatch++;
         rd <= 1'b0;
         wr <= 1'b0;
      end
   endtask : bus
   task conv(input logic [15:0] v);
      @(posedge clk);
      done <= 1'b1;
      result <= v;
      @(posedge clk);
      done <= 1'b0;
      last = v;
   endtask : conv
   task master_frame(input logic [1:0] div, input logic mode);
      int half;
      logic [15:0] exp;
      begin
         cfg <= {1'($random(seed)), 1'($random(seed)), 1'b0, div};
         rdc <= mode;
         r = 16'($random(seed));
         repeat (6) @(posedge clk);
         chk("sclk idle", {31'h0, cfg[4]}, {31'h0, sclk_dev});
         chk("sclk oe", 32'h1, {31'h0, sclk_oe});
         half = exp_half(div, mode);
         exp = mode ? last : r;
         n_sync = 0;
         host.m_bits = 0;
         @(posedge clk);
         busy <= 1'b1;
         repeat (20) @(posedge clk);
         if (!mode)
            chk("sync before done", 32'h0, n_sync);
         busy <= 1'b0;
         conv(r);
         repeat (32 * half + 12) @(posedge clk);
         chk("master word", {16'h0, exp}, {16'h0, host.m_word});
         chk("master bits", 32'h10, host.m_bits);
         chk("sync length", 32 * half, n_sync);
      end
   endtask : master_frame
   task give_verdict;
      $display("checks %0d mismatches %0d", n_checks, n_mismatch);
      if (n_mismatch == 0 && n_checks > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask : give_verdict
   // ------------------------------------------------------------------
   // main sequence
   // ------------------------------------------------------------------
   initial
   begin
      clk = 1'b0;
      rst_n = 1'b0;
      {adr, rd, wr, wdata, busy, done, result, ser, cfg, rdc} = '0;
      {n_mismatch, n_checks, n_flag, n_sync} = '0;
      seed = 37;
      last = 16'h0;
      repeat (8) @(posedge clk);
      rst_n <= 1'b1;
      repeat (6) @(posedge clk);
      bus(1'b0, asop_pkg::OFS_MASK, 32'h0);
      chk("mask reset", {30'h0, asop_pkg::MASK_RESET}, got);
      bus(1'b0, asop_pkg::OFS_RESULT, 32'h0);
      chk("result reset", {16'h0, asop_pkg::RESULT_RESET}, got);
      r = 16'($random(seed));
      conv(r);
      repeat (6) @(posedge clk);
      chk("pin oe", 32'h3c, {26'h0, cfg_oe});
      chk("pin data", {28'h0, r[7:4]}, {28'h0, cfg_out[5:2]});
      bus(1'b1, asop_pkg::OFS_RESULT, 32'h0000ffff);
      bus(1'b0, asop_pkg::OFS_RESULT, 32'h0);
      chk("result ro", {16'h0, r}, got);
      bus(1'b0, 4'h2, 32'h0);
      chk("unmapped", 32'h0, got);
      ser <= 1'b1;
      repeat (6) @(posedge clk);
      chk("serial oe", 32'h0, {26'h0, cfg_oe});
      bus(1'b0, asop_pkg::OFS_STATE, 32'h0);
      chk("state reg", {24'h0, 5'h01, asop_pkg::ST_IDLE}, got);
      for (k = 0; k < 8; k++)
         master_frame(2'(k % 4), 1'(k / 4));
      chk("irq masked", 32'h0, {31'h0, irq});
      bus(1'b1, asop_pkg::OFS_MASK, 32'h1);
      repeat (2) @(posedge clk);
      chk("irq set", 32'h1, {31'h0, irq});
      bus(1'b1, asop_pkg::OFS_STATUS, 32'h1);
      repeat (2) @(posedge clk);
      chk("irq clear", 32'h0, {31'h0, irq});
      for (k = 0; k < 2; k++)
      begin
         cfg <= {1'(k), 1'b0, 1'b1, 2'b11};
         repeat (6) @(posedge clk);
         r = 16'($random(seed));
         chain = 16'($random(seed));
         conv(r);
         chk("slave oe", 32'h0, {31'h0, sclk_oe});
         host.slave_read(1'(k), chain, 32, word);
         chk("slave word", {r, chain}, word);
      end
      bus(1'b0, asop_pkg::OFS_STATUS, 32'h0);
      chk("status slave", 32'h1, got);
      bus(1'b1, asop_pkg::OFS_STATUS, 32'h3);
      conv(16'($random(seed)));
      fork
         host.slave_read(1'b0, 16'h0, 16, word);
         begin
            repeat (40) @(posedge clk);
            k = n_flag;
            conv(16'($random(seed)));
            repeat (4) @(posedge clk);
            chk("flag pulse", k + 1, n_flag);
         end
      join
      bus(1'b0, asop_pkg::OFS_STATUS, 32'h0);
      chk("status abort", 32'h1, {31'h0, got[1]});
      bus(1'b1, asop_pkg::OFS_MASK, 32'h3);
      repeat (2) @(posedge clk);
      chk("irq abort", 32'h1, {31'h0, irq});
      bus(1'b1, asop_pkg::OFS_STATUS, 32'h3);
      repeat (2) @(posedge clk);
      chk("irq abort clear", 32'h0, {31'h0, irq});
      give_verdict;
   end
   initial
   begin
      #400000;
      n_mismatch++;
      give_verdict;
   end
endmodule : tb_top
`default_nettype wire
